/* File: rbc_ctrl.sv */
/*
 * rbc_ctrl: render buffer control bits of the system control register,
 * the drawing status flags and the command status register, reached over
 * Avalon-MM. Assumes drawing engine and display timing run on clk.
 */
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module rbc_ctrl
    import rbc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [rbc_pkg::RBC_AW-1:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cmd_fetch,
    input wire logic [rbc_pkg::RBC_CMD_AW-1:0] cmd_fetch_addr,
    input wire logic trap_exec,
    input wire logic cmd_error,
    input wire logic cmd_suspend,
    input wire logic frame_end,
    input wire logic field_end,
    input wire logic [1:0] scan_mode,
    input wire logic gm_access,
    input wire logic gm_read,
    input wire logic fifo_pending,
    input wire logic flush_done,
    output logic draw_start,
    output logic draw_stop,
    output logic draw_busy,
    output logic drawing_reset,
    output logic display_buf_sel,
    output logic [1:0] buffer_mode,
    output logic flush_req
);
    import rbc_pkg::*;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic sw_rst;
        logic [1:0] disp_ctl;
        logic brk_req;
        logic disp_chg;
        logic rend_start;
        logic [1:0] buf_mode;
        logic brk_flag;
        logic trap_flag;
        logic err_flag;
        logic susp_flag;
        logic busy;
        logic buf_sel;
        logic [RBC_CMD_AW-1:0] cmd_addr;
        logic draw_start;
        logic draw_stop;
        logic flush_kick;
    } rbc_state_s;

    rbc_state_s st_r, st_nxt;

    // address match, used by both the read mux and the write decode
    function automatic logic hit(input logic [RBC_AW-1:0] a,
                                 input logic [RBC_AW-1:0] off);
        hit = (a == off);
    endfunction

    // ********************************************************************
    // bus strobes and events
    // ********************************************************************
    logic acc;
    logic wr_ctl;
    logic lane1;
    logic lane0;
    logic brk_now;
    logic trap_now;
    logic swap_edge;
    logic may_start;
    logic [31:0] rd_mux;

    // the access completes in the cycle waitrequest is low
    assign acc = (read | write) & ~st_r.waitreq;
    assign wr_ctl = write & acc & hit(address, RBC_OFF_CTL);
    assign lane1 = wr_ctl & byteenable[1];
    assign lane0 = wr_ctl & byteenable[0];
    assign brk_now = st_r.busy & st_r.brk_req & cmd_fetch;
    assign trap_now = st_r.busy & ~st_r.brk_req & trap_exec;
    // field end only counts in interlace sync video, frame end otherwise
    assign swap_edge = (scan_mode == RBC_SCAN_INT_VIDEO) ? field_end
                       : frame_end;
    // wait for the flush so drawing never reads stale memory
    assign may_start = st_r.rend_start & ~st_r.busy & ~st_r.flush_kick
                       & ~flush_req & ~st_r.sw_rst
                       & (st_r.disp_ctl != RBC_DCTL_SYNC_ONLY);

    // read mux; unused bits and unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0;
        if (hit(address, RBC_OFF_CTL)) begin
            rd_mux[RBC_B_SWRST] = st_r.sw_rst;
            rd_mux[RBC_B_DCTL +: 2] = st_r.disp_ctl;
            rd_mux[RBC_B_BRKREQ] = st_r.brk_req;
            rd_mux[RBC_B_DCHG] = st_r.disp_chg;
            rd_mux[RBC_B_RSTART] = st_r.rend_start;
            rd_mux[RBC_B_BMODE +: 2] = st_r.buf_mode;
        end else if (hit(address, RBC_OFF_STAT)) begin
            rd_mux[RBC_S_BRK] = st_r.brk_flag;
            rd_mux[RBC_S_TRAP] = st_r.trap_flag;
            rd_mux[RBC_S_ERR] = st_r.err_flag;
            rd_mux[RBC_S_SUSP] = st_r.susp_flag;
            rd_mux[RBC_S_BUSY] = st_r.busy;
            rd_mux[RBC_S_BSEL] = st_r.buf_sel;
            rd_mux[RBC_S_FLUSH] = flush_req;
        end else if (hit(address, RBC_OFF_CMD)) begin
            rd_mux[RBC_CMD_AW-1:0] = st_r.cmd_addr;
        end
    end

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.draw_start = 1'b0;
        st_nxt.draw_stop = 1'b0;
        st_nxt.flush_kick = 1'b0;
        // one wait cycle, then a one-cycle answer
        st_nxt.waitreq = ~((read | write) & st_r.waitreq);
        if ((read | write) & st_r.waitreq) begin
            st_nxt.rdata = rd_mux;
        end

        // drawing engine events
        if (brk_now) begin
            st_nxt.brk_flag = 1'b1;
            st_nxt.busy = 1'b0;
            st_nxt.draw_stop = 1'b1;
            st_nxt.cmd_addr = cmd_fetch_addr;
            st_nxt.brk_req = 1'b0;
        end else if (trap_now) begin
            st_nxt.trap_flag = 1'b1;
            st_nxt.busy = 1'b0;
            st_nxt.draw_stop = 1'b1;
        end else if (st_r.busy & cmd_error) begin
            st_nxt.err_flag = 1'b1;
            st_nxt.busy = 1'b0;
            st_nxt.draw_stop = 1'b1;
        end
        if (st_r.busy & cmd_suspend) begin
            st_nxt.susp_flag = 1'b1;
        end
        if (may_start) begin
            st_nxt.busy = 1'b1;
            st_nxt.draw_start = 1'b1;
            st_nxt.rend_start = 1'b0;
        end

        // manual swap; auto modes leave the selection to the engines
        if (st_r.buf_mode == RBC_BM_MANUAL && st_r.disp_chg && swap_edge) begin
            st_nxt.buf_sel = ~st_r.buf_sel;
            st_nxt.disp_chg = 1'b0;
        end

        // host writes; a host set in the same cycle beats a hardware clear
        if (lane1) begin
            st_nxt.sw_rst = writedata[RBC_B_SWRST];
            st_nxt.disp_ctl = writedata[RBC_B_DCTL +: 2];
            st_nxt.brk_req = writedata[RBC_B_BRKREQ];
            if (writedata[RBC_B_DCHG]) begin
                st_nxt.disp_chg = 1'b1;
            end
            if (writedata[RBC_B_RSTART]) begin
                st_nxt.rend_start = 1'b1;
                st_nxt.flush_kick = 1'b1;
            end
        end
        // the prohibited code is dropped, keeping the old mode
        if (lane0 && writedata[RBC_B_BMODE +: 2] != RBC_BM_PROHIB) begin
            st_nxt.buf_mode = writedata[RBC_B_BMODE +: 2];
        end

        // drawing reset holds the drawing side cleared while set
        if (st_r.sw_rst) begin
            st_nxt.err_flag = 1'b0;
            st_nxt.trap_flag = 1'b0;
            st_nxt.susp_flag = 1'b0;
            st_nxt.brk_flag = 1'b0;
            st_nxt.busy = 1'b0;
            if (!lane1) begin
                st_nxt.brk_req = 1'b0;
            end
        end
    end

    // state register; everything resets to constants
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.waitreq <= 1'b1;
            st_r.disp_ctl <= RBC_DCTL_RST;
            st_r.buf_mode <= RBC_BMODE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // FIFO flush control
    // ********************************************************************
    rbc_flush #(
        .IDLE_CYCLES(RBC_IDLE_CYCLES),
        .IDLE_W(8)
    ) u_flush (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush_kick(st_r.flush_kick),
        .gm_access(gm_access),
        .gm_read(gm_read),
        .fifo_pending(fifo_pending),
        .flush_done(flush_done),
        .flush_req(flush_req)
    );

    // outputs straight from the state register
    assign readdata = st_r.rdata;
    assign waitrequest = st_r.waitreq;
    assign draw_start = st_r.draw_start;
    assign draw_stop = st_r.draw_stop;
    assign draw_busy = st_r.busy;
    assign drawing_reset = st_r.sw_rst;
    assign display_buf_sel = st_r.buf_sel;
    assign buffer_mode = st_r.buf_mode;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_BRK_STOP: assert property ((brk_now && !st_r.sw_rst) |=>
        st_r.brk_flag && !st_r.busy && draw_stop)
        else $error("break did not stop drawing");
    AST_BRK_IDLE: assert property ((!st_r.busy && !st_r.sw_rst) |=>
        st_r.brk_flag == $past(st_r.brk_flag))
        else $error("break flag moved while idle");
    AST_CMD_LOAD: assert property (brk_now |=>
        st_r.cmd_addr == $past(cmd_fetch_addr))
        else $error("command status not loaded on break");
    AST_BRK_KEEP: assert property ((st_r.brk_req && !brk_now && !lane1
        && !st_r.sw_rst) |=> st_r.brk_req)
        else $error("break request dropped without a break");
    AST_TRAP: assert property ((trap_now && !st_r.sw_rst) |=>
        st_r.trap_flag && !st_r.busy)
        else $error("trap did not set flag and stop");
    AST_SWAP: assert property ((st_r.buf_mode == RBC_BM_MANUAL
        && st_r.disp_chg && swap_edge) |=>
        (display_buf_sel != $past(display_buf_sel)) && !st_r.disp_chg)
        else $error("manual swap missed");
    AST_NO_SWAP: assert property ((!st_r.disp_chg) |=>
        $stable(display_buf_sel))
        else $error("buffer swapped without request");
    AST_START: assert property (may_start |=>
        draw_start && st_r.busy && !st_r.rend_start)
        else $error("rendering did not start");
    AST_SYNC_ONLY: assert property (
        (st_r.disp_ctl == RBC_DCTL_SYNC_ONLY) |=> !draw_start)
        else $error("drawing started in sync only mode");
    AST_SWRST: assert property (st_r.sw_rst |=>
        !st_r.trap_flag && !st_r.err_flag && !st_r.brk_flag
        && !st_r.susp_flag)
        else $error("drawing reset left a flag set");
    AST_MODE: assert property (buffer_mode != RBC_BM_PROHIB)
        else $error("prohibited buffer mode held");
    AST_ZERO_WR: assert property ((st_r.disp_chg && lane1
        && !writedata[RBC_B_DCHG] && !swap_edge) |=> st_r.disp_chg)
        else $error("zero write cancelled a display change");
    AST_WAIT: assert property (((read || write) && waitrequest) |=>
        !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle");

    COV_BREAK: cover property (brk_now);
    COV_TRAP: cover property (trap_now);
    COV_SWAP: cover property (st_r.disp_chg ##1 !st_r.disp_chg);
    COV_START: cover property (draw_start);
endmodule

/* File: rbc_fifo_model.sv */
/*
 * rbc_fifo_model: stand-in for the host-interface write FIFO on the flush
 * port. Assumes one clock; a fill pulse marks data as pending.
 */
`timescale 1ns/1ps
module rbc_fifo_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fill,
    input wire logic flush_req,
    input wire logic [3:0] lat,
    output logic fifo_pending,
    output logic flush_done
);
    logic [3:0] cnt;

    // answers each flush lat + 1 cycles after the request; an empty FIFO still answers,
    // so a stray request can never hang the drawing start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 4'h0;
            fifo_pending <= 1'b0;
            flush_done <= 1'b0;
        end else begin
            flush_done <= 1'b0;
            if (fill) begin
                fifo_pending <= 1'b1;
            end
            if (!flush_req || flush_done) begin
                cnt <= 4'h0;
            end else if (cnt == lat) begin
                flush_done <= 1'b1;
                fifo_pending <= 1'b0;
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

/* File: rbc_flush.sv */
/*
 * rbc_flush: decides when the host-interface write FIFO must be flushed
 * into graphics memory. Assumes the FIFO itself lives outside and answers
 * flush_req with a one-cycle flush_done once it has emptied.
 */
`timescale 1ns/1ps
module rbc_flush
    import rbc_pkg::*;
#(
    parameter int IDLE_CYCLES = RBC_IDLE_CYCLES,
    parameter int IDLE_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flush_kick,
    input wire logic gm_access,
    input wire logic gm_read,
    input wire logic fifo_pending,
    input wire logic flush_done,
    output logic flush_req
);
    typedef struct packed {
        logic [IDLE_W-1:0] idle;
        logic req;
    } rbc_flush_s;

    localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(IDLE_CYCLES);

    rbc_flush_s st_r, st_nxt;

    // idle count saturates at the limit; any memory access restarts it
    always_comb begin
        st_nxt = st_r;
        if (gm_access) begin
            st_nxt.idle = '0;
        end else if (st_r.idle != IDLE_LIM) begin
            st_nxt.idle = st_r.idle + IDLE_W'(1);
        end
        if (flush_done) begin
            st_nxt.req = 1'b0;
        end
        // a new trigger in the done cycle wins, so no data is stranded
        if (flush_kick) begin
            st_nxt.req = 1'b1;
        end
        if (st_r.idle == IDLE_LIM && fifo_pending) begin
            st_nxt.req = 1'b1;
        end
        if (gm_read) begin
            st_nxt.req = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flush_req = st_r.req;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_KICK_FLUSH: assert property (flush_kick |=> flush_req)
        else $error("start did not request a flush");
    AST_IDLE_FLUSH: assert property (
        !gm_access [*8] ##1 (!gm_access && st_r.idle == IDLE_LIM
        && fifo_pending) |=> flush_req)
        else $error("idle host did not trigger a flush");
    AST_READ_FLUSH: assert property (gm_read |=> flush_req)
        else $error("memory read did not flush first");
    COV_IDLE: cover property (st_r.idle == IDLE_LIM && fifo_pending);
endmodule

/* File: rbc_pkg.sv */
/*
 * rbc_pkg: constants and types shared by the render buffer control block.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
 */
package rbc_pkg;

    // ********************************************************************
    // register offsets (byte addresses)
    // ********************************************************************
    localparam int RBC_AW = 4;
    localparam logic [RBC_AW-1:0] RBC_OFF_CTL = 4'h0;
    localparam logic [RBC_AW-1:0] RBC_OFF_STAT = 4'h4;
    localparam logic [RBC_AW-1:0] RBC_OFF_CMD = 4'h8;

    // ********************************************************************
    // system control field positions
    // ********************************************************************
    localparam int RBC_B_SWRST = 15;
    localparam int RBC_B_DCTL = 13;
    localparam int RBC_B_BRKREQ = 10;
    localparam int RBC_B_DCHG = 9;
    localparam int RBC_B_RSTART = 8;
    localparam int RBC_B_BMODE = 6;

    // status register field positions
    localparam int RBC_S_BRK = 0;
    localparam int RBC_S_TRAP = 1;
    localparam int RBC_S_ERR = 2;
    localparam int RBC_S_SUSP = 3;
    localparam int RBC_S_BUSY = 4;
    localparam int RBC_S_BSEL = 5;
    localparam int RBC_S_FLUSH = 6;

    // ********************************************************************
    // reset values and encodings
    // ********************************************************************
    localparam logic [1:0] RBC_DCTL_RST = 2'h2;
    localparam logic [1:0] RBC_DCTL_SYNC_ONLY = 2'h2;
    localparam logic [1:0] RBC_BMODE_RST = 2'h0;
    localparam int RBC_CMD_AW = 24;

    typedef enum logic [1:0] {
        RBC_BM_AUTO_DISP = 2'b00,
        RBC_BM_AUTO_REND = 2'b01,
        RBC_BM_MANUAL = 2'b10,
        RBC_BM_PROHIB = 2'b11
    } rbc_bmode_e;

    typedef enum logic [1:0] {
        RBC_SCAN_NONINT = 2'b00,
        RBC_SCAN_INT = 2'b01,
        RBC_SCAN_INT_VIDEO = 2'b10
    } rbc_scan_e;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int RBC_CLK_NS = 10;
    localparam int RBC_BUS_CYCLE_NS = 10;
    localparam int RBC_IDLE_BUS_CYCLES = 32;
    localparam int RBC_IDLE_CYCLES =
        (RBC_IDLE_BUS_CYCLES * RBC_BUS_CYCLE_NS + RBC_CLK_NS - 1) / RBC_CLK_NS;

endpackage

/* File: tb_render_buffer_control_bits.sv */
/*
 * tb_render_buffer_control_bits: register-level tests of rbc_ctrl.
 * Assumes the FIFO model on the flush port and a 100 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin \
    miscompares++; $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); \
    end end
`define PULSE(s) begin @(posedge clk); s <= 1'b1; @(posedge clk); \
    s <= 1'b0; end
`define WAITFOR(c, n) begin k = 0; while (!(c) && k < n) begin \
    @(negedge clk); k++; end end
module tb_render_buffer_control_bits;
    import rbc_pkg::*;
    logic clk, sys_rst, read, write, cmd_fetch, trap_exec, frame_end;
    logic field_end, gm_access, gm_read, fifo_pending, flush_done, fill;
    logic waitrequest, draw_start, draw_stop, draw_busy, drawing_reset;
    logic display_buf_sel, flush_req, cmd_suspend;
    logic [3:0] address, lat;
    logic [31:0] writedata, readdata, d;
    logic [23:0] cmd_fetch_addr;
    logic [1:0] scan_mode, buffer_mode;
    logic exp_sel;
    int miscompares, tests_run, k;

    rbc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .address(address),
        .byteenable(4'hF), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cmd_fetch(cmd_fetch),
        .cmd_fetch_addr(cmd_fetch_addr), .trap_exec(trap_exec),
        .cmd_error(1'b0), .cmd_suspend(cmd_suspend), .frame_end(frame_end),
        .field_end(field_end), .scan_mode(scan_mode),
        .gm_access(gm_access), .gm_read(gm_read),
        .fifo_pending(fifo_pending), .flush_done(flush_done),
        .draw_start(draw_start), .draw_stop(draw_stop),
        .draw_busy(draw_busy), .drawing_reset(drawing_reset),
        .display_buf_sel(display_buf_sel), .buffer_mode(buffer_mode),
        .flush_req(flush_req));
    rbc_fifo_model fifo (.clk(clk), .sys_rst(sys_rst), .fill(fill),
        .flush_req(flush_req), .lat(lat), .fifo_pending(fifo_pending),
        .flush_done(flush_done));

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    // request held until the edge that samples waitrequest low
    task automatic xfer(input logic [3:0] a, input logic [31:0] wd,
                        input logic wr);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        n = 0;
        // waitrequest and read data are taken at the completing edge
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        `CHK("waitrequest", 1'b0, waitrequest)
        d = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] ex,
                       input logic [31:0] m);
        xfer(a, 32'h0, 1'b0);
        `CHK("readdata", ex, d & m)
    endtask

    // fill the FIFO together with a host access so the idle timer restarts
    task automatic fill_fifo(input logic rd_too);
        @(posedge clk);
        fill <= 1'b1;
        gm_access <= 1'b1;
        gm_read <= rd_too;
        @(posedge clk);
        fill <= 1'b0;
        gm_access <= 1'b0;
        gm_read <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // clock, reset and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        {sys_rst, read, write, cmd_fetch, trap_exec, frame_end} = 6'h20;
        {field_end, gm_access, gm_read, fill, cmd_suspend} = 5'h0;
        {address, writedata, cmd_fetch_addr, scan_mode} = 62'h0;
        lat = 4'hC;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(RBC_OFF_CTL, 32'h4000, 32'hFFFF);
        rdc(RBC_OFF_STAT, 32'h0, 32'h7F);
        xfer(4'hC, 32'hFFFF, 1'b1);
        rdc(4'hC, 32'h0, 32'hFFFFFFFF);
        // break request while idle
        xfer(RBC_OFF_CTL, 32'h4400, 1'b1);
        repeat (5) @(posedge clk);
        rdc(RBC_OFF_STAT, 32'h0, 32'h1F);
        rdc(RBC_OFF_CTL, 32'h4400, 32'hFFFF);
        // start refused while the display pair is sync only
        xfer(RBC_OFF_CTL, 32'h4100, 1'b1);
        repeat (10) @(negedge clk);
        `CHK("draw_busy", 1'b0, draw_busy)
        // let the refused start's flush drain so the next one is fresh
        `WAITFOR(flush_req === 1'b0, 30)
        // start flushes the FIFO first, slow FIFO answer
        fill_fifo(1'b0);
        xfer(RBC_OFF_CTL, 32'h0100, 1'b1);
        `WAITFOR(flush_req === 1'b1, 10)
        `CHK("flush_req", 1'b1, flush_req)
        `CHK("draw_busy", 1'b0, draw_busy)
        `WAITFOR(draw_busy === 1'b1, 40)
        `CHK("draw_busy", 1'b1, draw_busy)
        `CHK("draw_start", 1'b1, draw_start)
        rdc(RBC_OFF_CTL, 32'h0000, 32'hFFFF);
        // suspend while drawing, then a trap ends drawing
        `PULSE(cmd_suspend)
        `PULSE(trap_exec)
        @(negedge clk);
        `CHK("draw_stop", 1'b1, draw_stop)
        rdc(RBC_OFF_STAT, 32'h0A, 32'h1F);
        xfer(RBC_OFF_CTL, 32'h8000, 1'b1);
        @(negedge clk);
        `CHK("drawing_reset", 1'b1, drawing_reset)
        xfer(RBC_OFF_CTL, 32'h0000, 1'b1);
        rdc(RBC_OFF_STAT, 32'h00, 32'h1F);
        // break at the next fetch, prompt FIFO answer
        lat <= 4'h2;
        xfer(RBC_OFF_CTL, 32'h0100, 1'b1);
        `WAITFOR(draw_busy === 1'b1, 40)
        xfer(RBC_OFF_CTL, 32'h0400, 1'b1);
        repeat (4) @(negedge clk);
        `CHK("draw_busy", 1'b1, draw_busy)
        cmd_fetch_addr <= 24'hA5C3E1;
        `PULSE(cmd_fetch)
        @(negedge clk);
        `CHK("draw_stop", 1'b1, draw_stop)
        rdc(RBC_OFF_STAT, 32'h01, 32'h1F);
        rdc(RBC_OFF_CMD, 32'hA5C3E1, 32'hFFFFFF);
        rdc(RBC_OFF_CTL, 32'h0000, 32'hFFFF);
        xfer(RBC_OFF_CTL, 32'h8000, 1'b1);
        xfer(RBC_OFF_CTL, 32'h0000, 1'b1);
        rdc(RBC_OFF_STAT, 32'h00, 32'h1F);
        // every buffer mode, then the prohibited code
        for (int m = 0; m < 4; m++) begin
            xfer(RBC_OFF_CTL, 32'(m) << RBC_B_BMODE, 1'b1);
            @(negedge clk);
            `CHK("buffer_mode", 2'(m > 2 ? 2 : m), buffer_mode)
        end
        // manual swaps on the boundary of each scan mode
        exp_sel = 1'b0;
        for (int s = 0; s < 3; s++) begin
            scan_mode <= 2'(s);
            xfer(RBC_OFF_CTL, 32'h0280, 1'b1);
            xfer(RBC_OFF_CTL, 32'h0080, 1'b1);
            rdc(RBC_OFF_CTL, 32'h0280, 32'hFFFF);
            if (s == 2) `PULSE(field_end) else `PULSE(frame_end)
            repeat (2) @(negedge clk);
            exp_sel = !exp_sel;
            `CHK("display_buf_sel", exp_sel, display_buf_sel)
            rdc(RBC_OFF_CTL, 32'h0080, 32'hFFFF);
        end
        scan_mode <= 2'h0;
        `PULSE(frame_end)
        repeat (2) @(negedge clk);
        `CHK("display_buf_sel", exp_sel, display_buf_sel)
        // host read of graphics memory flushes at once
        fill_fifo(1'b1);
        `WAITFOR(flush_req === 1'b1, 3)
        `CHK("flush_req", 1'b1, flush_req)
        `WAITFOR(fifo_pending === 1'b0, 20)
        // idle host flushes after the idle span only
        fill_fifo(1'b0);
        repeat (RBC_IDLE_CYCLES - 4) @(negedge clk);
        `CHK("flush_req", 1'b0, flush_req)
        `WAITFOR(flush_req === 1'b1, 10)
        `CHK("flush_req", 1'b1, flush_req)
        repeat (20) @(posedge clk);
        print_verdict();
    end
endmodule
